/* File: dss_start_sequencer.sv */
`timescale 1ns/10ps

// What this block does
// - Start method 0 is direct start, 1 is speed-tracking restart, 2 is pre-excitation start.
// - Direct start with zero injection duration runs at once from the launch frequency.
// - Direct start with nonzero injection duration brakes with DC for that time, then runs.
// - Tracking restart finds the spinning speed and direction and starts at that frequency.
// - Pre-excitation applies only to asynchronous motors and builds the field before running.
// - Zero injection duration skips pre-excitation, otherwise pre-excite for that time first.
// - Tracking direction 0 searches down from loss frequency, 1 up from zero, 2 down from maximum.
// - Tracking rate takes 1 to 100, default 2, and a larger value searches faster.
// - Launch frequency takes 0.00 Hz to 10.00 Hz and is the first output frequency of a direct or pre-excitation start.
// - Output is held at launch frequency for the hold time, 0.0 s to 100.0 s, before accelerating.
// - A target below the launch frequency keeps the drive in standby at zero output.
// - Hold time is outside acceleration and is skipped on a direction-reversal switch.
// - Injection current level is 0 % to 100 % of rated drive current.
module dss_start_sequencer import dss_pkg::*; #(
  parameter int unsigned TICK_CYC  = TENTH_SEC_CYC,
  parameter int unsigned TRACK_CYC = TRACK_STEP_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic [15:0] est_freq,
  input  wire logic        est_dir,
  output logic [15:0]      out_freq,
  output logic             out_dir,
  output logic             dc_brake,
  output logic             preexcite,
  output logic [6:0]       inj_current,
  output logic             accel_enable,
  output logic             standby
);

  typedef struct packed {
    logic        hready;
    logic [31:0] hrdata;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [3:0]  ctrl;
    logic [1:0]  cfg_method;
    logic [1:0]  cfg_dir;
    logic [6:0]  cfg_rate;
    logic [15:0] cfg_launch;
    logic [15:0] cfg_hold;
    logic [6:0]  cfg_cur;
    logic [15:0] cfg_dur;
    logic [15:0] target_f;
    logic [15:0] max_f;
    logic [15:0] loss_f;
    logic        run_q;
    dss_state_t  state;
    logic [1:0]  l_method;
    logic [1:0]  l_dir;
    logic [6:0]  l_rate;
    logic [15:0] l_launch;
    logic [15:0] l_hold;
    logic [6:0]  l_cur;
    logic [15:0] l_dur;
    logic        l_async;
    logic        l_rev;
    logic [31:0] sub_cnt;
    logic [15:0] tenth_cnt;
    logic [15:0] search;
    logic [15:0] out_freq;
    logic        out_dir;
    logic        dc_brake;
    logic        preexc;
    logic [6:0]  inj;
    logic        accel_en;
    logic        standby;
  } dss_regs_t;

  dss_regs_t s_ff;
  dss_regs_t nxt_s;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] dss_clamp(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction : dss_clamp

  function automatic logic [6:0] dss_rate_fit(input logic [6:0] v);
    logic [6:0] f;
    f = v;
    if (v < RATE_MIN) begin
      f = RATE_MIN;
    end else if (v > RATE_MAX) begin
      f = RATE_MAX;
    end
    return f;
  endfunction : dss_rate_fit

  function automatic logic [6:0] dss_cur_fit(input logic [6:0] v);
    return (v > CURRENT_MAX) ? CURRENT_MAX : v;
  endfunction : dss_cur_fit

  function automatic dss_state_t dss_after_inject(input dss_regs_t r);
    dss_state_t st;
    st = DSS_HOLD;
    if (r.l_rev || r.l_hold == 16'h0) begin
      st = DSS_RUN;
    end
    return st;
  endfunction : dss_after_inject

  function automatic logic [15:0] dss_track_origin(input dss_regs_t r);
    logic [15:0] f;
    f = r.loss_f;
    unique case (r.l_dir)
      TRACK_FROM_ZERO: f = 16'h0;
      TRACK_FROM_MAX:  f = r.max_f;
      default:         f = r.loss_f;
    endcase
    return f;
  endfunction : dss_track_origin

  function automatic logic [15:0] dss_step_down(input logic [15:0] v, input logic [6:0] rate);
    logic [15:0] f;
    f = 16'h0;
    if (v > {9'h0, rate}) begin
      f = v - {9'h0, rate};
    end
    return f;
  endfunction : dss_step_down

  function automatic logic [31:0] dss_read(input dss_regs_t r, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    unique case (a)
      ADDR_CTRL:      d = {28'h0, r.ctrl};
      ADDR_START_CFG: d = {17'h0, r.cfg_rate, 2'h0, r.cfg_dir, 2'h0, r.cfg_method};
      ADDR_LAUNCH_F:  d = {16'h0, r.cfg_launch};
      ADDR_LAUNCH_T:  d = {16'h0, r.cfg_hold};
      ADDR_INJECTION: d = {r.cfg_dur, 9'h0, r.cfg_cur};
      ADDR_TARGET_F:  d = {16'h0, r.target_f};
      ADDR_MAX_F:     d = {16'h0, r.max_f};
      ADDR_LOSS_F:    d = {16'h0, r.loss_f};
      ADDR_STATUS:    d = {24'h0, r.standby, r.accel_en, r.preexc, r.dc_brake, 1'b0, r.state};
      ADDR_OUT_F:     d = {15'h0, r.out_dir, r.out_freq};
      default:        d = 32'h0;
    endcase
    return d;
  endfunction : dss_read

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        addr_ok;
    logic        tick;
    logic        tenth_done;
    logic [15:0] limit;
    logic [16:0] up_sum;
    addr_ok    = 1'b0;
    tick       = 1'b0;
    tenth_done = 1'b0;
    limit      = 16'h0;
    up_sum     = 17'h0;
    nxt_s      = s_ff;
    nxt_s.hready = 1'b1;

    // Bus data phase: write lands from the latched address
    if (s_ff.wr_pend) begin
      unique case (s_ff.wr_addr)
        ADDR_CTRL:      nxt_s.ctrl = hwdata[3:0];
        ADDR_START_CFG: begin
          nxt_s.cfg_method = hwdata[CFG_METHOD_LSB +: 2];
          nxt_s.cfg_dir    = hwdata[CFG_DIR_LSB +: 2];
          nxt_s.cfg_rate   = hwdata[CFG_RATE_LSB +: 7];
        end
        ADDR_LAUNCH_F:  nxt_s.cfg_launch = hwdata[15:0];
        ADDR_LAUNCH_T:  nxt_s.cfg_hold = hwdata[15:0];
        ADDR_INJECTION: begin
          nxt_s.cfg_cur = hwdata[6:0];
          nxt_s.cfg_dur = hwdata[INJ_DUR_LSB +: 16];
        end
        ADDR_TARGET_F:  nxt_s.target_f = hwdata[15:0];
        ADDR_MAX_F:     nxt_s.max_f = hwdata[15:0];
        ADDR_LOSS_F:    nxt_s.loss_f = hwdata[15:0];
        default:        nxt_s.ctrl = s_ff.ctrl;
      endcase
    end

    // Bus address phase: reads return next cycle, a write just made is forwarded
    nxt_s.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      addr_ok = 1'b1;
      nxt_s.wr_pend = hwrite;
      nxt_s.wr_addr = haddr[7:0];
      if (!hwrite) begin
        nxt_s.hrdata = dss_read(nxt_s, haddr[7:0]);
      end
    end

    // Run command edge and 0.1 s tick
    nxt_s.run_q = s_ff.ctrl[CTRL_RUN_BIT];
    if (s_ff.sub_cnt == 32'(TICK_CYC - 1)) begin
      tick = 1'b1;
      nxt_s.sub_cnt = 32'h0;
    end else begin
      nxt_s.sub_cnt = s_ff.sub_cnt + 32'h1;
    end
    limit = (s_ff.state == DSS_HOLD) ? s_ff.l_hold : s_ff.l_dur;
    if (tick) begin
      nxt_s.tenth_cnt = s_ff.tenth_cnt + 16'h1;
      tenth_done = (s_ff.tenth_cnt + 16'h1) >= limit;
    end

    // Sequencer
    if (!s_ff.ctrl[CTRL_RUN_BIT]) begin
      nxt_s.state = DSS_IDLE;
    end else begin
      unique case (s_ff.state)
        DSS_IDLE: begin
          if (!s_ff.run_q) begin
            nxt_s.state    = DSS_START;
            nxt_s.l_method = s_ff.cfg_method;
            nxt_s.l_dir    = s_ff.cfg_dir;
            nxt_s.l_rate   = dss_rate_fit(s_ff.cfg_rate);
            nxt_s.l_launch = dss_clamp(s_ff.cfg_launch, LAUNCH_MAX);
            nxt_s.l_hold   = dss_clamp(s_ff.cfg_hold, TIME_MAX);
            nxt_s.l_cur    = dss_cur_fit(s_ff.cfg_cur);
            nxt_s.l_dur    = dss_clamp(s_ff.cfg_dur, TIME_MAX);
            nxt_s.l_async  = s_ff.ctrl[CTRL_ASYNC_BIT];
            nxt_s.l_rev    = s_ff.ctrl[CTRL_REV_BIT];
            nxt_s.out_dir  = s_ff.ctrl[CTRL_DIR_BIT];
          end
        end
        DSS_START, DSS_STANDBY: begin
          nxt_s.sub_cnt   = 32'h0;
          nxt_s.tenth_cnt = 16'h0;
          if (s_ff.target_f < s_ff.l_launch) begin
            nxt_s.state = DSS_STANDBY;
          end else begin
            unique case (s_ff.l_method)
              METHOD_TRACK: begin
                nxt_s.state  = DSS_TRACK;
                nxt_s.search = dss_track_origin(s_ff);
              end
              METHOD_PREEXC: begin
                nxt_s.state = (s_ff.l_async && s_ff.l_dur != 16'h0) ? DSS_PREEXC :
                              dss_after_inject(s_ff);
              end
              default: begin
                nxt_s.state = (s_ff.l_dur != 16'h0) ? DSS_BRAKE : dss_after_inject(s_ff);
              end
            endcase
          end
        end
        DSS_BRAKE, DSS_PREEXC: begin
          if (tenth_done) begin
            nxt_s.state     = dss_after_inject(s_ff);
            nxt_s.sub_cnt   = 32'h0;
            nxt_s.tenth_cnt = 16'h0;
          end
        end
        DSS_TRACK: begin
          if (s_ff.sub_cnt == 32'(TRACK_CYC - 1)) begin
            nxt_s.sub_cnt = 32'h0;
          end
          if (s_ff.l_dir == TRACK_FROM_ZERO) begin
            up_sum = {1'b0, s_ff.search} + {10'h0, s_ff.l_rate};
            if (s_ff.search >= est_freq || s_ff.search >= s_ff.max_f) begin
              nxt_s.state   = DSS_RUN;
              nxt_s.out_dir = est_dir;
            end else if (s_ff.sub_cnt == 32'(TRACK_CYC - 1)) begin
              nxt_s.search = (up_sum > {1'b0, s_ff.max_f}) ? s_ff.max_f : up_sum[15:0];
            end
          end else begin
            if (s_ff.search <= est_freq) begin
              nxt_s.state   = DSS_RUN;
              nxt_s.out_dir = est_dir;
            end else if (s_ff.sub_cnt == 32'(TRACK_CYC - 1)) begin
              nxt_s.search = dss_step_down(s_ff.search, s_ff.l_rate);
            end
          end
        end
        DSS_HOLD: begin
          if (s_ff.l_rev || s_ff.l_hold == 16'h0 || tenth_done) begin
            nxt_s.state = DSS_RUN;
          end
        end
        DSS_RUN: nxt_s.state = DSS_RUN;
      endcase
    end

    // Outputs follow the next state
    nxt_s.dc_brake = (nxt_s.state == DSS_BRAKE);
    nxt_s.preexc   = (nxt_s.state == DSS_PREEXC);
    nxt_s.inj      = (nxt_s.dc_brake || nxt_s.preexc) ? s_ff.l_cur : 7'h0;
    nxt_s.accel_en = (nxt_s.state == DSS_RUN);
    nxt_s.standby  = (nxt_s.state == DSS_STANDBY);
    unique case (nxt_s.state)
      DSS_HOLD:  nxt_s.out_freq = s_ff.l_launch;
      DSS_TRACK: nxt_s.out_freq = nxt_s.search;
      DSS_RUN:   nxt_s.out_freq = (s_ff.state == DSS_RUN) ? s_ff.out_freq :
                                  (s_ff.state == DSS_TRACK) ? s_ff.search : s_ff.l_launch;
      default:   nxt_s.out_freq = 16'h0;
    endcase
    if (!addr_ok) begin
      nxt_s.hrdata = s_ff.hrdata;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_ff          <= '0;
      s_ff.hready   <= 1'b1;
      s_ff.state    <= DSS_IDLE;
      s_ff.cfg_rate <= RATE_RST;
      s_ff.l_rate   <= RATE_RST;
      s_ff.max_f    <= MAX_F_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout    = s_ff.hready;
  assign hrdata       = s_ff.hrdata;
  assign hresp        = 1'b0;
  assign out_freq     = s_ff.out_freq;
  assign out_dir      = s_ff.out_dir;
  assign dc_brake     = s_ff.dc_brake;
  assign preexcite    = s_ff.preexc;
  assign inj_current  = s_ff.inj;
  assign accel_enable = s_ff.accel_en;
  assign standby      = s_ff.standby;

endmodule : dss_start_sequencer

/* File: dss_pkg.sv */
package dss_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned TENTH_SEC_NS   = 100_000_000;
  localparam int unsigned TENTH_SEC_CYC  = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned TRACK_STEP_NS  = 1_000_000;
  localparam int unsigned TRACK_STEP_CYC = TRACK_STEP_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_START_CFG = 8'h04;
  localparam logic [7:0] ADDR_LAUNCH_F  = 8'h08;
  localparam logic [7:0] ADDR_LAUNCH_T  = 8'h0c;
  localparam logic [7:0] ADDR_INJECTION = 8'h10;
  localparam logic [7:0] ADDR_TARGET_F  = 8'h14;
  localparam logic [7:0] ADDR_MAX_F     = 8'h18;
  localparam logic [7:0] ADDR_LOSS_F    = 8'h1c;
  localparam logic [7:0] ADDR_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_OUT_F     = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_REV_BIT   = 1;
  localparam int CTRL_ASYNC_BIT = 2;
  localparam int CTRL_DIR_BIT   = 3;
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_DIR_LSB    = 4;
  localparam int CFG_RATE_LSB   = 8;
  localparam int INJ_DUR_LSB    = 16;

  // ---------------------------------------------------------------
  // Encodings, limits and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]  METHOD_DIRECT  = 2'h0;
  localparam logic [1:0]  METHOD_TRACK   = 2'h1;
  localparam logic [1:0]  METHOD_PREEXC  = 2'h2;
  localparam logic [1:0]  TRACK_FROM_LOSS = 2'h0;
  localparam logic [1:0]  TRACK_FROM_ZERO = 2'h1;
  localparam logic [1:0]  TRACK_FROM_MAX  = 2'h2;
  localparam logic [6:0]  RATE_MIN       = 7'h01;
  localparam logic [6:0]  RATE_MAX       = 7'h64;
  localparam logic [6:0]  RATE_RST       = 7'h02;
  localparam logic [15:0] LAUNCH_MAX     = 16'h03e8;
  localparam logic [15:0] TIME_MAX       = 16'h03e8;
  localparam logic [6:0]  CURRENT_MAX    = 7'h64;
  localparam logic [15:0] MAX_F_RST      = 16'h1388;

  typedef enum logic [2:0] {
    DSS_IDLE, DSS_START, DSS_STANDBY, DSS_BRAKE, DSS_PREEXC, DSS_TRACK, DSS_HOLD, DSS_RUN
  } dss_state_t;

endpackage : dss_pkg

/* File: dss_start_sequencer_chk.sv */
`timescale 1ns/10ps

module dss_start_sequencer_chk import dss_pkg::*; #(
  parameter int unsigned TICK_CYC = TENTH_SEC_CYC
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] out_freq,
  input wire logic        dc_brake,
  input wire logic        preexcite,
  input wire logic [6:0]  inj_current,
  input wire logic        accel_enable,
  input wire logic        standby
);
  // ----
  // Phase length counters
  // ----
  logic [31:0] brk_ff;
  logic [31:0] pre_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brk_ff <= 32'h0;
      pre_ff <= 32'h0;
    end else begin
      brk_ff <= dc_brake ? brk_ff + 32'h1 : 32'h0;
      pre_ff <= preexcite ? pre_ff + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // Assertions
  // ----
  AST_BUS_OK: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  AST_EXCL: assert property (!(dc_brake && preexcite)) else $error("brake and preexcite together");
  AST_INJ_MAX: assert property (inj_current <= CURRENT_MAX) else $error("current above limit");
  AST_INJ_IDLE: assert property (!dc_brake && !preexcite |-> inj_current == 7'h00)
    else $error("current outside injection");
  AST_STANDBY: assert property (standby |-> out_freq == 16'h0000 && !accel_enable)
    else $error("standby with output");
  AST_NO_RUN: assert property (dc_brake || preexcite |-> !accel_enable)
    else $error("accelerating during injection");
  AST_BRK_TICK: assert property ($fell(dc_brake) && out_freq != 16'h0 |-> brk_ff % TICK_CYC == 0)
    else $error("brake not whole ticks");
  AST_PRE_TICK: assert property ($fell(preexcite) && out_freq != 16'h0 |-> pre_ff % TICK_CYC == 0)
    else $error("preexcite not whole ticks");
  AST_LAUNCH: assert property ($fell(dc_brake) |-> out_freq <= LAUNCH_MAX)
    else $error("launch above limit");
  cover property ($rose(dc_brake));
  cover property ($rose(preexcite));
  cover property ($rose(standby));
  cover property ($rose(accel_enable));
endmodule : dss_start_sequencer_chk

bind dss_start_sequencer dss_start_sequencer_chk #(.TICK_CYC(TICK_CYC)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .out_freq(out_freq),
  .dc_brake(dc_brake), .preexcite(preexcite), .inj_current(inj_current),
  .accel_enable(accel_enable), .standby(standby)
);

/* File: dss_motor_model.sv */
`timescale 1ns/10ps

module dss_motor_model import dss_pkg::*; (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [15:0] spin_freq,
  input wire logic        spin_dir,
  input wire logic [15:0] out_freq,
  input wire logic        out_dir,
  input wire logic        dc_brake,
  input wire logic        accel_enable,
  output logic     [15:0] est_freq,
  output logic            est_dir
);
  // ----
  // Speed estimate: coasting, braked or driven
  // ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      est_freq <= 16'h0;
      est_dir  <= 1'b0;
    end else begin
      est_freq <= accel_enable ? out_freq : (dc_brake ? 16'h0 : spin_freq);
      est_dir  <= accel_enable ? out_dir : spin_dir;
    end
  end
endmodule : dss_motor_model

/* File: dss_start_sequencer_tb.sv */
`timescale 1ns/10ps

module dss_start_sequencer_tb import dss_pkg::*; ();
  logic        hclk, hresetn, hsel, hwrite, spin_dir, dr;
  logic [31:0] haddr, hwdata, rd;
  logic [31:0] seed = 32'h9517;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] spin_freq, fq, lf;
  logic [6:0]  cur;
  wire logic   hreadyout, hresp, out_dir, dc_brake, preexcite, accel_enable, standby, est_dir;
  wire logic [31:0] hrdata;
  wire logic [15:0] out_freq, est_freq;
  wire logic [6:0]  inj_current;
  int err_total, samples_checked, t, nb, np, nh, sb, ni, s, t2;
  logic [1:0] rm [6] = '{METHOD_DIRECT, METHOD_DIRECT, METHOD_DIRECT, METHOD_PREEXC, METHOD_PREEXC, METHOD_PREEXC};
  logic [3:0] rc [6] = '{4'h1, 4'h1, 4'h3, 4'h5, 4'h1, 4'h5};
  int rdur [6] = '{3, 0, 0, 2, 2, 0};
  int rr [4] = '{7, 100, 2, 100};
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  dss_start_sequencer #(.TICK_CYC(10), .TRACK_CYC(4)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .est_freq(est_freq), .est_dir(est_dir), .out_freq(out_freq), .out_dir(out_dir),
    .dc_brake(dc_brake), .preexcite(preexcite), .inj_current(inj_current),
    .accel_enable(accel_enable), .standby(standby));
  dss_motor_model i_motor (
    .hclk(hclk), .hresetn(hresetn), .spin_freq(spin_freq), .spin_dir(spin_dir), .out_freq(out_freq),
    .out_dir(out_dir), .dc_brake(dc_brake), .accel_enable(accel_enable), .est_freq(est_freq),
    .est_dir(est_dir));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic end_of_test();
    if (err_total == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    if (n >= 50) begin err_total++; end_of_test(); end
  endtask : bus
  // ----
  // One start: program, run, watch phases until acceleration
  // ----
  task automatic go(input logic [1:0] m, input logic [1:0] dir, input logic [6:0] rate,
                    input logic [15:0] dur, input logic [15:0] tgt, input logic [3:0] ctl, input int lim);
    bus(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    bus(1'b1, ADDR_START_CFG, {17'h0, rate, 2'h0, dir, 2'h0, m});
    bus(1'b1, ADDR_LAUNCH_F, {16'h0, lf});
    bus(1'b1, ADDR_LAUNCH_T, 32'h2);
    bus(1'b1, ADDR_INJECTION, {dur, 9'h0, cur});
    bus(1'b1, ADDR_TARGET_F, {16'h0, tgt});
    bus(1'b1, ADDR_LOSS_F, 32'hbb8);
    bus(1'b1, ADDR_CTRL, {28'h0, ctl});
    t = 0; nb = 0; np = 0; nh = 0; sb = 0; ni = 0;
    while (accel_enable !== 1'b1 && t < lim) begin
      @(posedge hclk);
      t++;
      nb += (dc_brake === 1'b1);
      np += (preexcite === 1'b1);
      ni += ((dc_brake === 1'b1 || preexcite === 1'b1) && inj_current !== cur);
      nh += (out_freq === lf && dc_brake === 1'b0 && preexcite === 1'b0 && accel_enable === 1'b0);
      sb |= (standby === 1'b1);
    end
    fq = out_freq;
    dr = out_dir;
    if (t >= lim && tgt >= lf) begin err_total++; end_of_test(); end
  endtask : go
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h0;
    hwdata = 32'h0; spin_freq = 16'd1234; spin_dir = 1'b1; err_total = 0; samples_checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, ADDR_START_CFG, 32'h0);
    chk("rate_reset", rd, 32'h200);
    bus(1'b0, ADDR_MAX_F, 32'h0);
    chk("max_reset", rd, {16'h0, MAX_F_RST});
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int k = 0; k < 6; k++) begin
      cur = 7'(rnd() % 100 + 1);
      lf = 16'(rnd() % 999 + 1);
      go(rm[k], 2'h0, 7'h2, 16'(rdur[k]), lf + 16'(rnd() % 500), rc[k], 300);
      chk("brake_cycles", nb, (rm[k] == METHOD_DIRECT) ? rdur[k] * 10 : 0);
      chk("preexc_cycles", np, (rm[k] == METHOD_PREEXC && rc[k][2]) ? rdur[k] * 10 : 0);
      chk("hold_cycles", nh, rc[k][1] ? 0 : 20);
      chk("inj_level", ni, 0);
      chk("launch_freq", fq, lf);
    end
    lf = 16'd500;
    go(METHOD_DIRECT, 2'h0, 7'h2, 16'h0, 16'd200, 4'h1, 60);
    chk("standby_seen", sb, 1);
    chk("standby_accel", accel_enable, 1'b0);
    chk("standby_freq", out_freq, 16'h0);
    lf = 16'h0;
    cur = 7'h0;
    for (int k = 0; k < 4; k++) begin
      go(METHOD_TRACK, (k > 2) ? 2'h2 : 2'(k), 7'(rr[k]), 16'h0, 16'd1000, 4'h1, 20000);
      case (k)
        0: s = 3000 - ((3000 - 1234 + rr[k] - 1) / rr[k]) * rr[k];
        1: s = ((1234 + rr[k] - 1) / rr[k]) * rr[k];
        default: s = 5000 - ((5000 - 1234 + rr[k] - 1) / rr[k]) * rr[k];
      endcase
      chk("track_freq", fq, s);
      chk("track_dir", dr, 1'b1);
      if (k == 2) t2 = t;
    end
    chk("rate_faster", t < t2, 1'b1);
    end_of_test();
  end
endmodule : dss_start_sequencer_tb
